// >>> sim/aems_chk.sv
// Purpose: assertions on the memory side of the sequencer
// Assumes: input_clock period is four clk_i cycles
// Notes: wait-count lengths are judged by the bench
`default_nettype none
module aems_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [aems_pkg::NBANKS-1:0] memory_bank_selects_n_o,
  input wire logic boot_memory_select_n_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic data_oe_o,
  input wire logic ext_ack_i
);
  import aems_pkg::*;
  wire logic sel = !(&memory_bank_selects_n_o) || !boot_memory_select_n_o;
  wire logic stb = !rd_n_o || !wr_n_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // selects go low one cycle ahead of the strobe
  sequence s_lead;
    sel && !stb ##1 sel && stb;
  endsequence
  a_sel_leads: assert property ($rose(sel) |-> s_lead)
    else $error("strobe late after selects");
  a_no_early: assert property ($rose(stb) |-> $past(sel))
    else $error("strobe before selects");
  a_min_width: assert property ($rose(stb) |-> stb[*4])
    else $error("strobe too short");
  a_ack_closes: assert property ($fell(stb) |-> $past(ext_ack_i, 2))
    else $error("strobe ended without ack");
  a_sel_outlast: assert property ($fell(stb) |-> sel)
    else $error("selects dropped early");
  a_drive_write: assert property (!wr_n_o |-> data_oe_o && rd_n_o)
    else $error("write data not driven");
  a_quiet_read: assert property (!rd_n_o |-> !data_oe_o)
    else $error("data driven in read");
  a_drive_free: assert property ($rose(wr_n_o) |-> ##[1:5] !data_oe_o)
    else $error("data not released");
  a_data_hold: assert property ($rose(wr_n_o) |-> data_oe_o)
    else $error("data dropped with strobe");
endmodule // aems_chk
bind aems_seq aems_chk i_chk (.*);
`default_nettype wire

// >>> sim/aems_mem.sv
// Purpose: behavioural async memory beyond the sequencer
// Assumes: ack and read data move just after clk_i edges
// Notes: ack_dly_i of zero answers at once, more stretches
`default_nettype none
module aems_mem (
  input wire logic clk_i,
  input wire logic [23:0] addr_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [31:0] wdat_i,
  input wire logic oe_i,
  input wire logic [7:0] ack_dly_i,
  output logic [31:0] rdat_o = 32'h0,
  output logic ack_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem_q [16];
  logic [7:0] cnt_q = 8'h00;
  wire logic idle = rd_n_i && wr_n_i;
  // a slow answer keeps ack low from the first cycle
  always @(posedge clk_i) begin
    cnt_q <= idle ? 8'h00 : cnt_q + 8'h01;
    ack_o <= idle ? (ack_dly_i == 8'h00) : (cnt_q >= ack_dly_i);
  end
  // undriven data is stored inverted so it cannot pass
  always @(posedge clk_i) begin
    rdat_o <= !rd_n_i ? mem_q[addr_i[3:0]] : ~rdat_o;
    if (!wr_n_i) mem_q[addr_i[3:0]] <= oe_i ? wdat_i : ~wdat_i;
  end
endmodule // aems_mem
`default_nettype wire

// >>> sim/test_async_ext_memory_master_strobes.sv
// Purpose: self-checking bench for the async strobe sequencer
// Assumes: prompt or slow memory model on the far side
// Notes: registers reached by classic single cycles
`default_nettype none
module test_async_ext_memory_master_strobes;
  timeunit 1ns;
  timeprecision 1ps;
  import aems_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack, rd_n, wr_n, oe, eack, bt_n;
  logic [3:0] adr = 4'h0, ms_n;
  logic [31:0] wd = 32'h0, rdat, xd, xq, bd;
  logic [23:0] xa;
  logic [7:0] dly = 8'h00;
  logic [4:0] seen;
  int error_cnt = 0, num_checks = 0, cc = 0, stc = 0, slc = 0, slen, ssel;
  initial forever #5 clk_i = ~clk_i;
  aems_seq i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_addr_o(xa), .memory_bank_selects_n_o(ms_n), .boot_memory_select_n_o(bt_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(xd), .data_oe_o(oe), .data_i(xq), .ext_ack_i(eack));
  aems_mem i_mem (.clk_i, .addr_i(xa), .rd_n_i(rd_n), .wr_n_i(wr_n), .wdat_i(xd),
    .oe_i(oe), .ack_dly_i(dly), .rdat_o(xq), .ack_o(eack));
  // strobe and select tallies; a hang is cut off here
  always @(posedge clk_i) begin
    cc <= cc + 1;
    if (!rst_i) begin
      stc <= stc + int'(!rd_n || !wr_n);
      slc <= slc + int'(!(&ms_n) || !bt_n);
    end
    if (!rd_n || !wr_n) seen <= {bt_n, ms_n};
    if (cc == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // request held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    bd = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic acc(input logic [31:0] cfg, input logic [7:0] cmd, input logic [31:0] d);
    int s0, l0;
    bus(1'b1, REG_CFG, cfg);
    bus(1'b1, REG_ADDR, {28'h0, d[3:0]});
    bus(1'b1, REG_DATA, d);
    s0 = stc;
    l0 = slc;
    bus(1'b1, REG_CMD, {24'h0, cmd});
    do bus(1'b0, REG_CMD, 32'h0); while (bd[STAT_BUSY_BIT] === 1'b1);
    while (!(&ms_n) || !bt_n || oe) @(posedge clk_i);
    slen = stc - s0;
    ssel = slc - l0;
  endtask
  task automatic sc_reset;
    bus(1'b0, REG_CFG, 32'h0);
    chk(bd, CFG_RESET);
    chk({rd_n, wr_n, oe, bt_n, ms_n}, 32'h0df);
  endtask
  task automatic sc_waits;
    for (int w = 0; w < 3; w++) begin
      acc(CFG_RESET | w, 8'h03, 32'h5a00_0000 | w);
      chk(slen, CYC_PER_ICLK * (w + 1));
      acc(CFG_RESET | w, 8'h01, w);
      chk(slen, CYC_PER_ICLK * (w + 1));
      bus(1'b0, REG_DATA, 32'h0);
      chk(bd, 32'h5a00_0000 | w);
    end
  endtask
  task automatic sc_selects;
    for (int k = 0; k < 5; k++) begin
      acc(CFG_RESET, k < 4 ? 8'h03 | 8'(k << 4) : 8'h07, 32'h0);
      chk(seen, k < 4 ? {1'b1, ~(4'h1 << k)} : 5'h0f);
    end
  endtask
  task automatic sc_hold;
    int s;
    acc(CFG_RESET, 8'h03, 32'ha7);
    s = ssel;
    acc(CFG_RESET | (32'h1 << CFG_HOLD_BIT), 8'h03, 32'hb7);
    chk(ssel - s, CYC_PER_ICLK);
    acc(CFG_RESET | 32'h300, 8'h01, 32'h7);
    bus(1'b0, REG_DATA, 32'h0);
    chk(bd, 32'hb7);
  endtask
  task automatic sc_stretch;
    dly <= 8'h14;
    acc(CFG_RESET | 32'h1, 8'h03, 32'hc9);
    chk(32'(slen > 32'h14), 32'h1);
    chk(slen % CYC_PER_ICLK, 32'h0);
    acc(CFG_RESET | 32'h1, 8'h01, 32'h9);
    bus(1'b0, REG_DATA, 32'h0);
    chk(bd, 32'hc9);
    dly <= 8'h00;
  endtask
  task automatic sc_refuse;
    acc(32'h0, 8'h03, 32'h1);
    chk(slen, 32'h0);
    chk(bd[STAT_ERR_BIT], 32'h1);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // reset for five cycles, then every scenario in turn
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    sc_reset();
    sc_waits();
    sc_selects();
    sc_hold();
    sc_stretch();
    sc_refuse();
    close_out();
  end
endmodule // test_async_ext_memory_master_strobes
`default_nettype wire

// >>> src/aems_pkg.sv
// Purpose: shared constants for the async external memory strobe sequencer
// Assumes: 100 MHz clk_i; one input_clock period is modelled as CYC_PER_ICLK clk_i cycles
// Notes: register map is reached over classic wishbone
`default_nettype none
package aems_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_CMD = 4'hc;
  // cfg fields
  localparam int CFG_WAIT_LSB = 0;
  localparam int CFG_WAIT_W = 5;
  localparam int CFG_HOLD_BIT = 8;
  localparam int CFG_IDLE_BIT = 9;
  localparam int CFG_ASYNC_BIT = 10;
  localparam logic [31:0] CFG_RESET = 32'h0000_0400;
  // cmd fields
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_BOOT_BIT = 2;
  localparam int CMD_BANK_LSB = 4;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_ERR_BIT = 9;
  // timing: input_clock period and input_clock quarter period in clk_i cycles
  localparam int CLK_NS = 10;
  localparam int ICLK_NS = 40;
  localparam int CYC_PER_ICLK = ICLK_NS / CLK_NS;
  localparam int QTR_CYC = (CYC_PER_ICLK / 4 < 1) ? 1 : CYC_PER_ICLK / 4;
  localparam int NBANKS = 4;
  // sequencer states
  typedef enum logic [2:0] {
    AEMS_IDLE = 3'b000,
    AEMS_SETUP = 3'b001,
    AEMS_STROBE = 3'b010,
    AEMS_ACKW = 3'b011,
    AEMS_HOLD = 3'b100,
    AEMS_GAP = 3'b101
  } aems_state_t;
endpackage : aems_pkg
`default_nettype wire

// >>> src/aems_seq.sv
// Purpose: bus-master sequencer for asynchronous external memory accesses
// Assumes: ext_ack_i synchronous to clk_i; one access in flight at a time
// Notes: software loads cfg, addr and data, then writes cmd with go set
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`default_nettype none
// How it works
// - sequence runs only for accesses to space configured asynchronous
// - address and selects first, strobe falls a quarter period later
// - each programmed wait state adds one input_clock period of strobe low
// - acknowledge ignored until all wait states are counted
// - acknowledge evaluated every input_clock edge from the second cycle
// - hold option keeps address, selects, write data one extra period
// - hold or idle option adds one period before the next strobe
// - idle option releases write data one period before the next strobe
// - data drivers enabled around write strobe fall, released shortly after rise
module aems_seq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [23:0] ext_addr_o,
  output logic [aems_pkg::NBANKS-1:0] memory_bank_selects_n_o,
  output logic boot_memory_select_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [31:0] data_o,
  output logic data_oe_o,
  input wire logic [31:0] data_i,
  input wire logic ext_ack_i
);
  import aems_pkg::*;
  aems_state_t state_q;
  logic [31:0] cfg_q, addr_q, wdata_q, rdata_q;
  logic [7:0] cmd_q;
  logic err_q, go_q, tick, restart, gap_pend_q;
  logic [7:0] qcnt_q;
  logic [CFG_WAIT_W-1:0] wcnt_q;
  logic wr_acc_q;

  // write one 32-bit register honouring byte enables
  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic wb_req, wb_wr, busy;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign busy = (state_q != AEMS_IDLE) || go_q;

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // config, address and write data; frozen while busy so the pins stay stable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= CFG_RESET;
      addr_q <= 32'h0;
      wdata_q <= 32'h0;
    end else if (wb_wr && !busy) begin
      if (wb_adr_i == REG_CFG) begin
        cfg_q <= wmask(cfg_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == REG_ADDR) begin
        addr_q <= wmask(addr_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == REG_DATA) begin
        wdata_q <= wmask(wdata_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  // command launch; a go to non-async space is refused and flagged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= 8'h0;
      go_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      // a go that lands during a pending gap must survive until the gap ends
      if (state_q == AEMS_IDLE && !gap_pend_q) begin
        go_q <= 1'b0;
      end
      if (wb_wr && !busy && wb_adr_i == REG_CMD && wb_sel_i[0]) begin
        cmd_q <= wb_dat_i[7:0];
        err_q <= wb_dat_i[CMD_GO_BIT] && !cfg_q[CFG_ASYNC_BIT];
        go_q <= wb_dat_i[CMD_GO_BIT] && cfg_q[CFG_ASYNC_BIT];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_req && !wb_we_i) begin
      if (wb_adr_i == REG_CFG) begin
        wb_dat_o <= cfg_q;
      end else if (wb_adr_i == REG_ADDR) begin
        wb_dat_o <= addr_q;
      end else if (wb_adr_i == REG_DATA) begin
        wb_dat_o <= rdata_q;
      end else if (wb_adr_i == REG_CMD) begin
        wb_dat_o <= {22'h0, err_q, busy, cmd_q};
      end else begin
        wb_dat_o <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // input_clock period ticks
  // ----------------------------------------------------------------
  // period restarts as the strobe falls, so the strobe spans whole periods
  assign restart = (state_q == AEMS_SETUP) && (qcnt_q == 8'(QTR_CYC - 1));
  aems_tick u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(restart),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= AEMS_IDLE;
      qcnt_q <= 8'h0;
      wcnt_q <= '0;
      wr_acc_q <= 1'b0;
      gap_pend_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      case (state_q)
        AEMS_IDLE: begin
          if (gap_pend_q) begin
            if (tick) begin
              gap_pend_q <= 1'b0;
            end
          end else if (go_q) begin
            state_q <= AEMS_SETUP;
            qcnt_q <= 8'h0;
            wr_acc_q <= cmd_q[CMD_WRITE_BIT];
            wcnt_q <= cfg_q[CFG_WAIT_LSB +: CFG_WAIT_W];
          end
        end
        AEMS_SETUP: begin
          // selects lead the strobe by a quarter input_clock period
          qcnt_q <= qcnt_q + 8'h01;
          if (qcnt_q == 8'(QTR_CYC - 1)) begin
            state_q <= AEMS_STROBE;
          end
        end
        AEMS_STROBE: begin
          // strobe just fell; ack is first looked at on the period's closing edge
          state_q <= AEMS_ACKW;
        end
        AEMS_ACKW: begin
          if (tick) begin
            if (wcnt_q != '0) begin
              wcnt_q <= wcnt_q - 1'b1;
            end else if (ext_ack_i) begin
              if (!wr_acc_q) begin
                rdata_q <= data_i;
              end
              state_q <= cfg_q[CFG_HOLD_BIT] ? AEMS_HOLD : AEMS_GAP;
            end
          end
        end
        AEMS_HOLD: begin
          if (tick) begin
            state_q <= AEMS_GAP;
          end
        end
        default: begin
          // strobe high, wait a quarter period then release
          qcnt_q <= 8'h0;
          gap_pend_q <= cfg_q[CFG_HOLD_BIT] || cfg_q[CFG_IDLE_BIT];
          state_q <= AEMS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic active, strobe, hold_ph;
  assign active = (state_q != AEMS_IDLE);
  assign strobe = (state_q == AEMS_STROBE) || (state_q == AEMS_ACKW);
  assign hold_ph = (state_q == AEMS_HOLD);

  // registered pins so all edges land on clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_addr_o <= 24'h0;
      memory_bank_selects_n_o <= '1;
      boot_memory_select_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      data_o <= 32'h0;
      data_oe_o <= 1'b0;
    end else begin
      ext_addr_o <= addr_q[23:0];
      for (int b = 0; b < NBANKS; b++) begin
        memory_bank_selects_n_o[b] <= !(active && !cmd_q[CMD_BOOT_BIT] &&
          cmd_q[CMD_BANK_LSB +: 2] == 2'(b));
      end
      boot_memory_select_n_o <= !(active && cmd_q[CMD_BOOT_BIT]);
      rd_n_o <= !(strobe && !wr_acc_q);
      wr_n_o <= !(strobe && wr_acc_q);
      data_o <= wdata_q;
      // drive from setup through hold; the gap state keeps data one cycle past strobe rise
      data_oe_o <= active && wr_acc_q;
    end
  end
endmodule // aems_seq
`default_nettype wire

// >>> src/aems_tick.sv
// Purpose: input_clock period tick generator for the sequencer
// Assumes: synchronous active-high reset
// Notes: restart realigns the period to a new access
`default_nettype none
module aems_tick (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  output logic tick_o
);
  import aems_pkg::*;
  logic [7:0] cnt_q;
  // ----------------------------------------------------------------
  // period counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      cnt_q <= 8'h00;
    end else if (cnt_q == 8'(CYC_PER_ICLK - 1)) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // tick marks the last clk_i cycle of each input_clock period
  assign tick_o = (cnt_q == 8'(CYC_PER_ICLK - 1)) && !restart_i;
endmodule // aems_tick
`default_nettype wire
